/* File: mrb_consts.svh */
// Constants for the multi-region readout and binning block.
// What this block does
// - Up to eight configurable sensor regions exist.
// - Active readout keeps only pixels inside enabled regions.
// - Enabled regions are stacked into one frame.
// - Selector picks region for per-region settings.
// - Each region has its own on/off bit.
// - Width shared; offsets and height per region.
// - Frame is common width by summed heights.
// - Read-only flag shows settings are valid.
// - Status shows active while regions are in use.
// - Selector picks sensor or logic binning.
// - Horizontal binning sums or averages adjacent pixels.
// - Vertical binning sums or averages adjacent lines.
// - Horizontal factor 1, 2, 4; 4 mono only.
// - Vertical factor 1, 2, 4; 4 mono only.
// - Two-by-two binning quarters the pixel count.
// - Sum quadruples response; average keeps it unchanged.
// - Binning change rescales maximum and current geometry.
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH

`define NREG 8
`define PIX_W 14
`define OUT_W 18
`define DIM_W 16
`define LINE_DEPTH 16384
`define SENSOR_W 16'h3440
`define SENSOR_H 16'h2538
`define H_ALIGN 5
`define V_ALIGN 2

`define A_CTRL 8'h00
`define A_WIDTH 8'h04
`define A_ENABLE 8'h08
`define A_OFFH 8'h0C
`define A_OFFV 8'h10
`define A_HEIGHT 8'h14
`define A_STATUS 8'h18
`define A_MAXW 8'h1C
`define A_MAXH 8'h20
`define A_IMGW 8'h24
`define A_IMGH 8'h28
`define A_IMGC 8'h2C
`define A_IMGR 8'h30
`define A_FRAMEH 8'h34

`define F_LOC 8
`define F_HAVG 9
`define F_VAVG 10
`define F_HLOG 12
`define F_VLOG 14

`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

/* File: mrb_pkg.sv */
// Types shared by the multi-region readout and binning block.
`include "mrb_consts.svh"
package mrb_pkg;
   typedef struct packed {
      logic valid;
      logic sof;
      logic eol;
      logic [`PIX_W-1:0] data;
   } pix_in_type;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eol;
      logic [`OUT_W-1:0] data;
   } pix_out_type;

   typedef enum logic {loc_sensor, loc_logic} bin_loc_type;
endpackage : mrb_pkg

/* File: bin_stage.sv */
// Horizontal and vertical pixel binning with a line accumulator.
`timescale 1ns/1ps
`include "mrb_consts.svh"
module bin_stage #(
   parameter int LINE_DEPTH = `LINE_DEPTH
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Binning setup, factors as log2
   input wire logic [1:0] h_log,
   input wire logic [1:0] v_log,
   input wire logic h_avg,
   input wire logic v_avg,
   // Streams
   input wire mrb_pkg::pix_in_type pix_in,
   output mrb_pkg::pix_out_type pix_out
);
   localparam int XW = $clog2(LINE_DEPTH);

   logic [`OUT_W-1:0] lbuf [LINE_DEPTH];
   logic [`OUT_W-1:0] hacc_r, hacc_nxt, hsum, hval, vsum;
   logic [1:0] hcnt_r, hcnt_nxt, vcnt_r, vcnt_nxt, h0, v0;
   logic [XW-1:0] x_r, x_nxt, x0;
   logic sofp_r, sofp_nxt, hlast, vlast, mem_we;
   mrb_pkg::pix_out_type out_nxt;

   function automatic logic [1:0] lmask(input logic [1:0] l);
      lmask = (l == 2'h0) ? 2'h0 : ((l == 2'h1) ? 2'h1 : 2'h3);
   endfunction : lmask

   always_comb begin
      h0 = pix_in.sof ? 2'h0 : hcnt_r;
      v0 = pix_in.sof ? 2'h0 : vcnt_r;
      x0 = pix_in.sof ? '0 : x_r;
      hsum = ((h0 == 2'h0) ? '0 : hacc_r) + `OUT_W'(pix_in.data);
      hval = hsum >> (h_avg ? h_log : 2'h0);
      hlast = (h0 == lmask(h_log));
      vsum = ((v0 == 2'h0) ? '0 : lbuf[x0]) + hval;
      vlast = (v0 == lmask(v_log));
      hacc_nxt = hacc_r;
      hcnt_nxt = hcnt_r;
      vcnt_nxt = vcnt_r;
      x_nxt = x_r;
      sofp_nxt = sofp_r | (pix_in.valid & pix_in.sof);
      mem_we = 1'b0;
      out_nxt = '0;
      if (pix_in.valid) begin
         hacc_nxt = hsum;
         hcnt_nxt = hlast ? 2'h0 : h0 + 2'h1;
         vcnt_nxt = v0;
         x_nxt = x0;
         if (hlast) begin
            mem_we = !vlast;
            x_nxt = x0 + XW'(1);
            if (vlast) begin
               // One output per factor-by-factor block of inputs.
               out_nxt.valid = 1'b1;
               out_nxt.sof = sofp_nxt;
               out_nxt.eol = pix_in.eol;
               out_nxt.data = vsum >> (v_avg ? v_log : 2'h0);
               sofp_nxt = 1'b0;
            end
         end
         if (pix_in.eol) begin
            // A partial group at a line end is dropped, widths are aligned.
            hcnt_nxt = 2'h0;
            x_nxt = '0;
            vcnt_nxt = vlast ? 2'h0 : v0 + 2'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hacc_r <= '0;
         hcnt_r <= 2'h0;
         vcnt_r <= 2'h0;
         x_r <= '0;
         sofp_r <= 1'b0;
         pix_out <= '0;
      end else begin
         hacc_r <= hacc_nxt;
         hcnt_r <= hcnt_nxt;
         vcnt_r <= vcnt_nxt;
         x_r <= x_nxt;
         sofp_r <= sofp_nxt;
         pix_out <= out_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (mem_we) begin
         lbuf[x0] <= vsum;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence first_of_pair;
      pix_in.valid && pix_in.sof && h_log == 2'h1 && v_log == 2'h0;
   endsequence

   chk_pair_no_early: assert property (
      first_of_pair |=> !pix_out.valid)
      else $error("binned pixel emitted after one input");
   chk_pair_sum: assert property (
      first_of_pair ##1 (pix_in.valid && !h_avg) |=>
         pix_out.valid && pix_out.data ==
         `OUT_W'($past(pix_in.data, 1)) + `OUT_W'($past(pix_in.data, 2)))
      else $error("horizontal pair sum wrong");
   chk_avg_bound: assert property (
      pix_out.valid && h_avg && v_avg |->
         pix_out.data[`OUT_W-1:`PIX_W] == '0)
      else $error("average exceeds single pixel range");
endmodule : bin_stage

/* File: multi_region_readout_binning.sv */
// Multi-region readout filter, binning control and AXI4-Lite registers.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "mrb_consts.svh"
module multi_region_readout_binning #(
   parameter bit MONO = 1'b1,
   parameter int LINE_DEPTH = `LINE_DEPTH
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite register slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pixel streams
   input wire mrb_pkg::pix_in_type pix_in,
   output mrb_pkg::pix_out_type pix_out,
   // Binning factors handed to the sensor, {v_log, h_log}
   output logic [3:0] sensor_bin_cfg
);
   localparam int N = `NREG;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rd_word;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt, ctrl_word, wv;
   logic [2:0] sel_r, sel_nxt;
   logic loc_r, loc_nxt, havg_r, havg_nxt, vavg_r, vavg_nxt;
   logic [1:0] hlog_r, hlog_nxt, vlog_r, vlog_nxt, hnew, vnew;
   logic [N-1:0] en_r, en_nxt;
   logic [`DIM_W-1:0] width_r, width_nxt;
   logic [`DIM_W-1:0] offh_r [N];
   logic [`DIM_W-1:0] offh_nxt [N];
   logic [`DIM_W-1:0] offv_r [N];
   logic [`DIM_W-1:0] offv_nxt [N];
   logic [`DIM_W-1:0] ht_r [N];
   logic [`DIM_W-1:0] ht_nxt [N];
   logic [`DIM_W-1:0] imgw_r, imgw_nxt, imgh_r, imgh_nxt;
   logic [`DIM_W-1:0] imgc_r, imgc_nxt, imgr_r, imgr_nxt;
   logic [`DIM_W-1:0] maxw, maxh, frame_h;
   logic settings_ok, active;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge

   function automatic logic fac_ok(input logic [1:0] l);
      fac_ok = (l == 2'h0) || (l == 2'h1) || (l == 2'h2 && MONO);
   endfunction : fac_ok

   function automatic logic [`DIM_W-1:0] rescale(
         input logic [`DIM_W-1:0] v, input logic [1:0] o,
         input logic [1:0] n);
      logic [`DIM_W+1:0] t;
      t = ({2'h0, v} << o) >> n;
      rescale = t[`DIM_W-1:0];
   endfunction : rescale

   // ----------------------------------------------------------------
   // Settings check and geometry
   // ----------------------------------------------------------------
   always_comb begin
      settings_ok = (width_r != '0) && (width_r[`H_ALIGN-1:0] == '0);
      frame_h = '0;
      for (int i = 0; i < N; i++) begin
         if (en_r[i]) begin
            frame_h = frame_h + ht_r[i];
            settings_ok = settings_ok
               && ({1'b0, offh_r[i]} + {1'b0, width_r} <= {1'b0, `SENSOR_W})
               && ({1'b0, offv_r[i]} + {1'b0, ht_r[i]} <= {1'b0, `SENSOR_H})
               && (offh_r[i][`H_ALIGN-1:0] == '0) && (ht_r[i] != '0)
               && (offv_r[i][`V_ALIGN-1:0] == '0)
               && (ht_r[i][`V_ALIGN-1:0] == '0);
         end
      end
      active = |en_r;
      maxw = `SENSOR_W >> hlog_r;
      maxh = `SENSOR_H >> vlog_r;
      ctrl_word = '0;
      ctrl_word[2:0] = sel_r;
      ctrl_word[`F_LOC] = loc_r;
      ctrl_word[`F_HAVG] = havg_r;
      ctrl_word[`F_VAVG] = vavg_r;
      ctrl_word[`F_HLOG +: 2] = hlog_r;
      ctrl_word[`F_VLOG +: 2] = vlog_r;
   end

   always_comb begin
      rd_word = '0;
      unique case (s_axi_araddr)
         `A_CTRL: rd_word = ctrl_word;
         `A_WIDTH: rd_word[`DIM_W-1:0] = width_r;
         `A_ENABLE: rd_word[0] = en_r[sel_r];
         `A_OFFH: rd_word[`DIM_W-1:0] = offh_r[sel_r];
         `A_OFFV: rd_word[`DIM_W-1:0] = offv_r[sel_r];
         `A_HEIGHT: rd_word[`DIM_W-1:0] = ht_r[sel_r];
         `A_STATUS: rd_word = {16'h0000, en_r, 6'h00, active, settings_ok};
         `A_MAXW: rd_word[`DIM_W-1:0] = maxw;
         `A_MAXH: rd_word[`DIM_W-1:0] = maxh;
         `A_IMGW: rd_word[`DIM_W-1:0] = imgw_r;
         `A_IMGH: rd_word[`DIM_W-1:0] = imgh_r;
         `A_IMGC: rd_word[`DIM_W-1:0] = imgc_r;
         `A_IMGR: rd_word[`DIM_W-1:0] = imgr_r;
         `A_FRAMEH: rd_word[`DIM_W-1:0] = frame_h;
         default: rd_word = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // Bus channels and register writes
   // ----------------------------------------------------------------
   always_comb begin
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
      bresp_nxt = s_axi_bresp;
      rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
      rdata_nxt = s_axi_rdata;
      rresp_nxt = s_axi_rresp;
      {sel_nxt, loc_nxt, havg_nxt, vavg_nxt} = {sel_r, loc_r, havg_r, vavg_r};
      {hlog_nxt, vlog_nxt, en_nxt, width_nxt} = {hlog_r, vlog_r, en_r, width_r};
      offh_nxt = offh_r;
      offv_nxt = offv_r;
      ht_nxt = ht_r;
      {imgw_nxt, imgh_nxt, imgc_nxt, imgr_nxt} = {imgw_r, imgh_r, imgc_r, imgr_r};
      wv = '0;
      hnew = hlog_r;
      vnew = vlog_r;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_nxt = s_axi_awaddr;
         aw_have_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
         w_have_nxt = 1'b1;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = `RESP_OK;
         unique case (awaddr_r)
            `A_CTRL: begin
               wv = merge(ctrl_word, wdata_r, wstrb_r);
               sel_nxt = wv[2:0];
               loc_nxt = wv[`F_LOC];
               havg_nxt = wv[`F_HAVG];
               vavg_nxt = wv[`F_VAVG];
               // An unsupported factor leaves the old factor in force.
               if (fac_ok(wv[`F_HLOG +: 2])) begin
                  hnew = wv[`F_HLOG +: 2];
               end
               if (fac_ok(wv[`F_VLOG +: 2])) begin
                  vnew = wv[`F_VLOG +: 2];
               end
               hlog_nxt = hnew;
               vlog_nxt = vnew;
               imgw_nxt = rescale(imgw_r, hlog_r, hnew);
               imgc_nxt = rescale(imgc_r, hlog_r, hnew);
               imgh_nxt = rescale(imgh_r, vlog_r, vnew);
               imgr_nxt = rescale(imgr_r, vlog_r, vnew);
            end
            `A_WIDTH: begin
               wv = merge({16'h0000, width_r}, wdata_r, wstrb_r);
               width_nxt = wv[`DIM_W-1:0];
            end
            `A_ENABLE: begin
               wv = merge({31'h0, en_r[sel_r]}, wdata_r, wstrb_r);
               en_nxt[sel_r] = wv[0];
            end
            `A_OFFH: begin
               wv = merge({16'h0000, offh_r[sel_r]}, wdata_r, wstrb_r);
               offh_nxt[sel_r] = wv[`DIM_W-1:0];
            end
            `A_OFFV: begin
               wv = merge({16'h0000, offv_r[sel_r]}, wdata_r, wstrb_r);
               offv_nxt[sel_r] = wv[`DIM_W-1:0];
            end
            `A_HEIGHT: begin
               wv = merge({16'h0000, ht_r[sel_r]}, wdata_r, wstrb_r);
               ht_nxt[sel_r] = wv[`DIM_W-1:0];
            end
            `A_IMGW: imgw_nxt = `DIM_W'(merge({16'h0000, imgw_r}, wdata_r,
               wstrb_r));
            `A_IMGH: imgh_nxt = `DIM_W'(merge({16'h0000, imgh_r}, wdata_r,
               wstrb_r));
            `A_IMGC: imgc_nxt = `DIM_W'(merge({16'h0000, imgc_r}, wdata_r,
               wstrb_r));
            `A_IMGR: imgr_nxt = `DIM_W'(merge({16'h0000, imgr_r}, wdata_r,
               wstrb_r));
            `A_STATUS, `A_MAXW, `A_MAXH, `A_FRAMEH: bresp_nxt = `RESP_OK;
            default: bresp_nxt = `RESP_ERR;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_word;
         rresp_nxt = (s_axi_araddr <= `A_FRAMEH && s_axi_araddr[1:0] == 2'h0)
            ? `RESP_OK : `RESP_ERR;
      end
      awready_nxt = !aw_have_nxt;
      wready_nxt = !w_have_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {awaddr_r, wdata_r, wstrb_r, aw_have_r, w_have_r} <= '0;
         {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h0;
         {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp} <= '0;
         s_axi_rdata <= '0;
         {sel_r, loc_r, havg_r, vavg_r, hlog_r, vlog_r} <= '0;
         loc_r <= mrb_pkg::loc_logic;
         en_r <= '0;
         width_r <= `SENSOR_W;
         offh_r <= '{default: '0};
         offv_r <= '{default: '0};
         ht_r <= '{default: '0};
         imgw_r <= `SENSOR_W;
         imgh_r <= `SENSOR_H;
         imgc_r <= '0;
         imgr_r <= '0;
         sensor_bin_cfg <= 4'h0;
      end else begin
         {awaddr_r, wdata_r, wstrb_r} <= {awaddr_nxt, wdata_nxt, wstrb_nxt};
         {aw_have_r, w_have_r} <= {aw_have_nxt, w_have_nxt};
         {s_axi_awready, s_axi_wready} <= {awready_nxt, wready_nxt};
         s_axi_arready <= arready_nxt;
         {s_axi_bvalid, s_axi_bresp} <= {bvalid_nxt, bresp_nxt};
         {s_axi_rvalid, s_axi_rresp} <= {rvalid_nxt, rresp_nxt};
         s_axi_rdata <= rdata_nxt;
         {sel_r, loc_r, havg_r, vavg_r} <= {sel_nxt, loc_nxt, havg_nxt, vavg_nxt};
         {hlog_r, vlog_r, en_r, width_r} <= {hlog_nxt, vlog_nxt, en_nxt, width_nxt};
         offh_r <= offh_nxt;
         offv_r <= offv_nxt;
         ht_r <= ht_nxt;
         {imgw_r, imgh_r, imgc_r, imgr_r} <= {imgw_nxt, imgh_nxt, imgc_nxt, imgr_nxt};
         sensor_bin_cfg <= (loc_r == mrb_pkg::loc_sensor) ? {vlog_r, hlog_r} : 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // Region filter: rows are scanned once, so stacking is scan order
   // ----------------------------------------------------------------
   logic [`DIM_W-1:0] col_r, col_nxt, row_r, row_nxt, c0, r0;
   logic sofp_r, sofp_nxt, keep, keep_eol;
   mrb_pkg::pix_in_type filt_r, filt_nxt;

   always_comb begin
      c0 = pix_in.sof ? '0 : col_r;
      r0 = pix_in.sof ? '0 : row_r;
      keep = !active;
      keep_eol = pix_in.eol;
      for (int i = 0; i < N; i++) begin
         if (en_r[i] && c0 >= offh_r[i] && c0 - offh_r[i] < width_r
               && r0 >= offv_r[i] && r0 - offv_r[i] < ht_r[i]) begin
            keep = 1'b1;
            keep_eol = (c0 - offh_r[i] == width_r - `DIM_W'(1));
         end
      end
      col_nxt = col_r;
      row_nxt = row_r;
      sofp_nxt = sofp_r | (pix_in.valid & pix_in.sof);
      filt_nxt = '0;
      if (pix_in.valid) begin
         col_nxt = pix_in.eol ? '0 : c0 + `DIM_W'(1);
         row_nxt = pix_in.eol ? r0 + `DIM_W'(1) : r0;
         if (keep) begin
            // One frame marker for all regions together.
            filt_nxt = {1'b1, sofp_nxt, keep_eol, pix_in.data};
            sofp_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {col_r, row_r, sofp_r} <= '0;
         filt_r <= '0;
      end else begin
         {col_r, row_r, sofp_r} <= {col_nxt, row_nxt, sofp_nxt};
         filt_r <= filt_nxt;
      end
   end

   // Sensor-side binning leaves the logic stage at factor one.
   bin_stage #(.LINE_DEPTH(LINE_DEPTH)) u_bin (
      .aclk(aclk),
      .aresetn(aresetn),
      .h_log(loc_r == mrb_pkg::loc_logic ? hlog_r : 2'h0),
      .v_log(loc_r == mrb_pkg::loc_logic ? vlog_r : 2'h0),
      .h_avg(havg_r),
      .v_avg(vavg_r),
      .pix_in(filt_r),
      .pix_out(pix_out)
   );

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
   chk_bresp_both: assert property ($rose(s_axi_bvalid)
      |-> $past(aw_have_r) && $past(w_have_r))
      else $error("write answer before address and data");
   chk_inactive_pass: assert property (
      en_r == '0 && pix_in.valid |=> filt_r.valid)
      else $error("pixel dropped while regions unused");
   chk_height_sel: assert property (
      aw_have_r && w_have_r && !s_axi_bvalid && awaddr_r == `A_HEIGHT
      && wstrb_r == 4'hF |=> ht_r[$past(sel_r)] == $past(wdata_r[15:0]))
      else $error("height not written to selected region");
   chk_mono_only: assert property (!MONO |-> hlog_r != 2'h2
      && vlog_r != 2'h2)
      else $error("factor four on colour variant");
   chk_align_bad: assert property (
      en_r[0] && offh_r[0][`H_ALIGN-1:0] != '0 |-> !settings_ok)
      else $error("misaligned region reported valid");
   chk_rescale_w: assert property ($changed(hlog_r) |->
      imgw_r == rescale($past(imgw_r), $past(hlog_r), hlog_r))
      else $error("image width not rescaled");
   chk_skip_out: assert property (
      filt_r.valid |-> $past(pix_in.valid))
      else $error("filtered pixel without input pixel");
endmodule : multi_region_readout_binning

/* File: sensor_feed.sv */
// Behavioural sensor readout that streams short test frames.
`timescale 1ns/1ps
module sensor_feed (
   // Clock
   input wire logic aclk,
   // Pixel stream towards the block
   output mrb_pkg::pix_in_type pix
);
   initial pix = '0;

   // Rows end early with eol so that test frames stay short.
   task automatic send(input int cols, input int rows, input int seed,
                       input bit slow);
      for (int r = 0; r < rows; r++) begin
         for (int c = 0; c < cols; c++) begin
            @(posedge aclk);
            pix <= '{1'b1, r == 0 && c == 0, c == cols - 1,
                     14'((seed + (r * cols + c) * 37) * 4)};
            // A slow sensor leaves gaps; the stale data is inverted.
            if (slow && c[0]) begin
               @(posedge aclk);
               pix <= '{1'b0, 1'b0, 1'b0, ~pix.data};
            end
         end
      end
      @(posedge aclk);
      pix <= '{1'b0, 1'b0, 1'b0, ~pix.data};
   endtask : send
endmodule : sensor_feed

/* File: tb.sv */
// Self-checking bench for the region readout and binning block.
`timescale 1ns/1ps
`include "mrb_consts.svh"
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] sensor_bin_cfg;
   mrb_pkg::pix_in_type pix_in;
   mrb_pkg::pix_out_type pix_out;
   int n_errors = 0;
   int cmp_count = 0;
   int exp_q[$];
   logic [31:0] lfsr_r = 32'h0000_1c2b;
   logic [15:0] ctl [4] = '{16'h5100, 16'h5700, 16'ha300, 16'h1100};

   always #5 aclk = ~aclk;

   multi_region_readout_binning #(.MONO(1'b1), .LINE_DEPTH(64))
   u_multi_region_readout_binning (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .pix_in(pix_in), .pix_out(pix_out), .sensor_bin_cfg(sensor_bin_cfg));

   sensor_feed u_sensor_feed (.aclk(aclk), .pix(pix_in));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int px(input int seed, input int idx);
      return ((seed + idx * 37) * 4) & 32'h0000_3fff;
   endfunction : px

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 200);
      if (s_axi_bvalid !== 1'b1) n_errors++;
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 200);
      if (s_axi_rvalid !== 1'b1) n_errors++;
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
   endtask : rd

   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // Every output pixel must be the next one the model predicts.
   always @(posedge aclk) begin
      if (pix_out.valid === 1'b1) begin
         if (exp_q.size() == 0) chk(32'(pix_out.data), 32'hffff_ffff);
         else chk(32'({pix_out.eol, pix_out.sof, pix_out.data}),
            32'(exp_q.pop_front()));
      end
   end

   // The whole run needs about 2000 cycles; this allows ten times that.
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      end_sim();
   end

   initial begin
      int seed, hl, vl, v, hs, ow;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`A_STATUS, 32'h0000_0001, `RESP_OK);
      rd(`A_MAXW, 32'h0000_3440, `RESP_OK);
      rd(8'h38, 32'h0000_0000, `RESP_ERR);
      wr(8'h40, 32'h0000_0001, `RESP_ERR);
      wr(`A_CTRL, 32'h0000_0100, `RESP_OK);
      wr(`A_WIDTH, 32'h0000_0020, `RESP_OK);
      wr(`A_ENABLE, 32'h0000_0001, `RESP_OK);
      wr(`A_OFFH, 32'h0000_0020, `RESP_OK);
      wr(`A_OFFV, 32'h0000_0004, `RESP_OK);
      wr(`A_HEIGHT, 32'h0000_0004, `RESP_OK);
      wr(`A_CTRL, 32'h0000_0101, `RESP_OK);
      wr(`A_ENABLE, 32'h0000_0001, `RESP_OK);
      wr(`A_OFFH, 32'h0000_0000, `RESP_OK);
      wr(`A_OFFV, 32'h0000_000c, `RESP_OK);
      wr(`A_HEIGHT, 32'h0000_0004, `RESP_OK);
      rd(`A_FRAMEH, 32'h0000_0008, `RESP_OK);
      rd(`A_STATUS, 32'h0000_0303, `RESP_OK);
      lfsr_r = lfsr(lfsr_r);
      seed = int'(lfsr_r[15:0]);
      for (int r = 0; r < 16; r++)
         for (int c = 0; c < 64; c++)
            if ((r >= 4 && r < 8 && c >= 32) || (r >= 12 && c < 32))
               exp_q.push_back(px(seed, r * 64 + c)
                  | int'(exp_q.size() == 0) << 18 | int'(c % 32 == 31) << 19);
      u_sensor_feed.send(64, 16, seed, 1'b1);
      repeat (4) @(posedge aclk);
      chk(32'(exp_q.size()), 32'h0000_0000);
      wr(`A_OFFH, 32'h0000_3440, `RESP_OK);
      rd(`A_STATUS, 32'h0000_0302, `RESP_OK);
      wr(`A_OFFH, 32'h0000_0000, `RESP_OK);
      wr(`A_ENABLE, 32'h0000_0000, `RESP_OK);
      wr(`A_CTRL, 32'h0000_0100, `RESP_OK);
      wr(`A_OFFH, 32'h0000_0010, `RESP_OK);
      rd(`A_STATUS, 32'h0000_0102, `RESP_OK);
      wr(`A_ENABLE, 32'h0000_0000, `RESP_OK);
      rd(`A_STATUS, 32'h0000_0001, `RESP_OK);
      wr(`A_CTRL, 32'h0000_4000, `RESP_OK);
      repeat (2) @(posedge aclk);
      chk(32'(sensor_bin_cfg), 32'h0000_0004);
      rd(`A_IMGH, 32'h0000_129c, `RESP_OK);
      for (int i = 0; i < 4; i++) begin
         hl = int'(ctl[i][13:12]);
         vl = int'(ctl[i][15:14]);
         ow = 8 >> hl;
         wr(`A_CTRL, 32'(ctl[i]), `RESP_OK);
         rd(`A_MAXW, 32'h0000_3440 >> hl, `RESP_OK);
         rd(`A_MAXH, 32'h0000_2538 >> vl, `RESP_OK);
         rd(`A_IMGW, 32'h0000_3440 >> hl, `RESP_OK);
         lfsr_r = lfsr(lfsr_r);
         seed = int'(lfsr_r[15:0]);
         for (int o = 0; o < (32 >> (hl + vl)); o++) begin
            v = 0;
            for (int d = 0; d < (1 << vl); d++) begin
               hs = 0;
               for (int e = 0; e < (1 << hl); e++)
                  hs += px(seed, ((o / ow) * (1 << vl) + d) * 8
                                 + (o % ow) * (1 << hl) + e);
               v += ctl[i][9] ? hs >> hl : hs;
            end
            exp_q.push_back((ctl[i][10] ? v >> vl : v)
               | int'(o == 0) << 18 | int'(o % ow == ow - 1) << 19);
         end
         u_sensor_feed.send(8, 4, seed, i[0]);
         repeat (4) @(posedge aclk);
         chk(32'(exp_q.size()), 32'h0000_0000);
      end
      end_sim();
   end
endmodule : tb
